// ### hw/rtcpc_core.sv
// prescaled real-time counter core with classic wishbone register slave
`timescale 1ns/1ps
module rtcpc_core
  import rtcpc_pkg::*;
(
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // oscillator source clock pin, sampled
  input  wire logic                         timekeeper_source_clock_i,
  // wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [4:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  output logic                              wb_err_o,
  // events and interrupt
  output logic                              event_ovf_o,
  output logic                              event_cmp_o,
  output logic                              irq_o
);
  import rtcpc_pkg::*;

  logic              osc_s1_r, osc_s2_r, osc_s3_r;
  logic              osc_edge;
  logic              enable_r;
  logic              run_r;
  logic              busy_r;
  rtcpc_cfg_s        cfg_r;
  logic [EV_W-1:0]   evctl_r;
  logic [EV_W-1:0]   irq_st_r;
  logic [EV_W-1:0]   irq_mk_r;
  logic [CNT_W-1:0]  count_r;
  logic [CNT_W-1:0]  cmp_r;
  logic [PSC_W-1:0]  psc_r;
  logic [PSC_W-1:0]  psc_mask;
  logic              tick;
  logic              hit;
  logic              wrap;
  logic [CNT_W-1:0]  count_nxt;
  logic [CNT_W-1:0]  cal_nxt;
  logic              cal_wrap;
  logic              acc;
  logic              wr;
  logic              mapped;
  logic              wr_ctrl;
  logic              prot_ok;
  logic [31:0]       rd_data;

  // two flops before the pin is looked at; third flop only for the edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end
    else
    begin
      osc_s1_r <= timekeeper_source_clock_i;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end
  assign osc_edge = osc_s2_r & ~osc_s3_r;

  // bus decode; one access per request, ack for one cycle
  assign acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign mapped  = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= ADDR_CMP);
  assign wr      = acc & mapped & wb_we_i;
  assign wr_ctrl = wr && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0] && wb_sel_i[1];
  // protected fields only while fully stopped, so a write clearing enable never carries them
  assign prot_ok = ~enable_r & ~run_r & ~busy_r; // [RULE3] [RULE5] [RULE6]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc & mapped;
      wb_err_o <= acc & ~mapped;
      wb_dat_o <= (acc & mapped & ~wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

  // read mux; unused bits read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_CTRL:
      begin
        rd_data[CTRL_EN_BIT]                     = enable_r;
        rd_data[CTRL_MODE_LSB +: 2]              = cfg_r.mode;
        rd_data[CTRL_HFMT_BIT]                   = cfg_r.hour_format_select;
        rd_data[CTRL_CLR_BIT]                    = cfg_r.clear_on_compare_hit;
        rd_data[CTRL_PSC_LSB +: PSC_SEL_W]       = cfg_r.psc;
      end
      ADDR_EVCTL: rd_data[EV_W-1:0] = evctl_r;
      ADDR_SYNC:  rd_data[0]        = busy_r;     // [RULE10]
      ADDR_IRQST: rd_data[EV_W-1:0] = irq_st_r;
      ADDR_IRQMK: rd_data[EV_W-1:0] = irq_mk_r;
      ADDR_COUNT: rd_data           = count_r;
      ADDR_CMP:   rd_data           = cmp_r;
      default:    rd_data           = 32'h0000_0000;
    endcase
  end

  // control word: enable always writable, the rest only when stopped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_r <= 1'b0;
      cfg_r    <= CFG_RST;
    end
    else if (wr_ctrl)
    begin
      enable_r <= wb_dat_i[CTRL_EN_BIT];
      if (prot_ok) // [RULE3] [RULE6]
      begin
        // reserved mode code falls back to the wide counter
        cfg_r.mode <= (wb_dat_i[CTRL_MODE_LSB +: 2] == 2'b11) ? RTCPC_WIDE
                    : rtcpc_mode_e'(wb_dat_i[CTRL_MODE_LSB +: 2]);
        cfg_r.hour_format_select   <= wb_dat_i[CTRL_HFMT_BIT];
        cfg_r.clear_on_compare_hit <= wb_dat_i[CTRL_CLR_BIT];
        cfg_r.psc <= (wb_dat_i[CTRL_PSC_LSB +: PSC_SEL_W] > PSC_MAX) ? PSC_MAX
                   : wb_dat_i[CTRL_PSC_LSB +: PSC_SEL_W];
      end
    end
  end

  // event output control is protected as a whole
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evctl_r <= '0;
    else if (wr && (wb_adr_i == ADDR_EVCTL) && wb_sel_i[0] && prot_ok) // [RULE4]
      evctl_r <= wb_dat_i[EV_W-1:0];
  end

  // enable crosses to the tick side at the next oscillator edge; busy until then
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_r  <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      if (osc_edge)
        run_r <= enable_r;
      if (wr_ctrl)
        busy_r <= 1'b1;                          // [RULE10]
      else if (osc_edge)
        busy_r <= 1'b0;                          // [RULE10]
    end
  end

  // prescaler: tick when the low psc bits are all ones, giving osc / 2^psc
  assign psc_mask = PSC_W'((11'h001 << cfg_r.psc) - 11'h001); // [RULE8]
  assign tick     = run_r & osc_edge & ((psc_r & psc_mask) == psc_mask); // [RULE1] [RULE8]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      psc_r <= '0;
    else if (run_r & osc_edge)                   // [RULE9] holds while stopped
      psc_r <= psc_r + PSC_W'(1);
  end

  // calendar step; 12-hour form keeps hours 1..12 with the pm flag in bit 4
  always_comb
  begin
    logic [5:0] s, m, y;
    logic [4:0] h, d, dmax;
    logic [3:0] mo;
    s = count_r[CAL_SEC_LSB +: 6];
    m = count_r[CAL_MIN_LSB +: 6];
    h = count_r[CAL_HR_LSB  +: 5];
    d = count_r[CAL_DAY_LSB +: 5];
    mo = count_r[CAL_MON_LSB +: 4];
    y = count_r[CAL_YR_LSB  +: 6];
    cal_wrap = 1'b0;
    unique case (mo)
      4'h2:                      dmax = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB:    dmax = 5'd30;
      default:                   dmax = 5'd31;
    endcase
    if (s < 6'd59)
      s = s + 6'd1;
    else
    begin
      s = 6'd0;
      if (m < 6'd59)
        m = m + 6'd1;
      else
      begin
        m = 6'd0;
        if (cfg_r.hour_format_select)
        begin
          // 11 -> 12 toggles am/pm; 12 -> 1 keeps it; day rolls at 12 am
          if (h[3:0] == 4'd11)
            h = {~h[4], 4'd12};
          else if (h[3:0] >= 4'd12)
            h = {h[4], 4'd1};
          else
            h = {h[4], h[3:0] + 4'd1};
        end
        else
          h = (h < 5'd23) ? h + 5'd1 : 5'd0;
        if (cfg_r.hour_format_select ? (h == 5'h0C) : (h == 5'd0))
        begin
          if (d < dmax)
            d = d + 5'd1;
          else
          begin
            d = 5'd1;
            if (mo < 4'd12)
              mo = mo + 4'd1;
            else
            begin
              mo = 4'd1;
              cal_wrap = (y == 6'd63);
              y = y + 6'd1;
            end
          end
        end
      end
    end
    cal_nxt = {y, mo, d, h, m, s};
  end

  // per-mode next count and wrap
  always_comb
  begin
    unique case (cfg_r.mode)                     // [RULE2]
      RTCPC_HALF:
      begin
        count_nxt = {16'h0000, count_r[15:0] + 16'h0001};
        wrap      = (count_r[15:0] == 16'hFFFF);
      end
      RTCPC_CAL:
      begin
        count_nxt = cal_nxt;
        wrap      = cal_wrap;
      end
      default:
      begin
        count_nxt = count_r + 32'h0000_0001;
        wrap      = (count_r == 32'hFFFF_FFFF);
      end
    endcase
  end

  assign hit = (cfg_r.mode == RTCPC_HALF) ? (count_r[15:0] == cmp_r[15:0]) : (count_r == cmp_r);

  // counter: software write wins, else one step per tick; on hit if asked, wide clears, calendar loads 0x0442_0000, half steps on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_r <= 32'h0000_0000;
    else if (wr && (wb_adr_i == ADDR_COUNT) && (&wb_sel_i))
      count_r <= wb_dat_i;
    else if (tick)                               // [RULE9]
    begin
      if (hit && cfg_r.clear_on_compare_hit && (cfg_r.mode != RTCPC_HALF))
        count_r <= (cfg_r.mode == RTCPC_CAL) ? 32'h0442_0000 : 32'h0000_0000;
      else
        count_r <= count_nxt;                    // [RULE1] [RULE2]
    end
  end

  // compare / alarm value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmp_r <= 32'h0000_0000;
    else if (wr && (wb_adr_i == ADDR_CMP) && (&wb_sel_i))
      cmp_r <= wb_dat_i;
  end

  // event pulses gated by event output control
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      event_ovf_o <= 1'b0;
      event_cmp_o <= 1'b0;
    end
    else
    begin
      event_ovf_o <= tick & wrap & evctl_r[EV_OVF_BIT];
      event_cmp_o <= tick & hit & evctl_r[EV_CMP_BIT];
    end
  end

  // sticky status, write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_st_r <= '0;
      irq_mk_r <= '0;
    end
    else
    begin
      irq_st_r <= (irq_st_r & ~((wr && (wb_adr_i == ADDR_IRQST) && wb_sel_i[0]) ? wb_dat_i[EV_W-1:0] : '0))
                | {tick & hit, tick & wrap};
      if (wr && (wb_adr_i == ADDR_IRQMK) && wb_sel_i[0])
        irq_mk_r <= wb_dat_i[EV_W-1:0];
    end
  end

  assign irq_o = |(irq_st_r & irq_mk_r);

endmodule

// ### hw/rtcpc_pkg.sv
// package for the prescaled real-time counter core: register map, fields, modes
// Notes on behaviour
// [RULE1] a 10-bit prescaler divides the source clock and steps a 32-bit counter
// [RULE2] modes: 0 wide 32-bit counter, 1 half 16-bit counter, 2 calendar with alarm
// [RULE3] mode, prescaler, clear-on-hit and hour format are written only while disabled
// [RULE4] the whole event output control register is written only while disabled
// [RULE5] software clears enable, waits for sync busy low, then changes protected fields
// [RULE6] protected fields ride along with enable set to 1, never with enable cleared
// [RULE7] in calendar mode software must set the prescaler for a 1 Hz tick
// [RULE8] tick rate is source clock rate divided by two to the prescaler setting
// [RULE9] enabled: counter steps once per tick; disabled: counter and prescaler hold
// [RULE10] sync busy stays high from an enable write until the counter side takes it
package rtcpc_pkg;

  // byte offsets of the word registers
  localparam logic [4:0] ADDR_CTRL  = 5'h00;
  localparam logic [4:0] ADDR_EVCTL = 5'h04;
  localparam logic [4:0] ADDR_SYNC  = 5'h08;
  localparam logic [4:0] ADDR_IRQST = 5'h0C;
  localparam logic [4:0] ADDR_IRQMK = 5'h10;
  localparam logic [4:0] ADDR_COUNT = 5'h14;
  localparam logic [4:0] ADDR_CMP   = 5'h18;

  // control_word_a field positions
  localparam int CTRL_EN_BIT   = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_HFMT_BIT = 6;
  localparam int CTRL_CLR_BIT  = 7;
  localparam int CTRL_PSC_LSB  = 8;

  localparam int PSC_W     = 10;
  localparam int PSC_SEL_W = 4;
  localparam logic [PSC_SEL_W-1:0] PSC_MAX = 4'hA;
  localparam int CNT_W     = 32;

  // event and interrupt bit positions (same layout in both registers)
  localparam int EV_OVF_BIT = 0;
  localparam int EV_CMP_BIT = 1;
  localparam int EV_W       = 2;

  // calendar field layout inside the counter word
  localparam int CAL_SEC_LSB = 0;
  localparam int CAL_MIN_LSB = 6;
  localparam int CAL_HR_LSB  = 12;
  localparam int CAL_DAY_LSB = 17;
  localparam int CAL_MON_LSB = 22;
  localparam int CAL_YR_LSB  = 26;

  typedef enum logic [1:0] {
    RTCPC_WIDE = 2'b00,   // wide_counter_mode
    RTCPC_HALF = 2'b01,   // half_counter_mode
    RTCPC_CAL  = 2'b10
  } rtcpc_mode_e;

  // protected part of control_word_a
  typedef struct packed {
    logic [PSC_SEL_W-1:0] psc;
    logic                 clear_on_compare_hit;
    logic                 hour_format_select;   // 1 selects 12-hour with pm flag
    rtcpc_mode_e          mode;
  } rtcpc_cfg_s;

  localparam rtcpc_cfg_s CFG_RST = '{psc: 4'h0, clear_on_compare_hit: 1'b0,
                                     hour_format_select: 1'b0, mode: RTCPC_WIDE};

endpackage

// ### tb/rtcpc_monitor.sv
// bus handshake and event pulse checker for the prescaled counter core
`timescale 1ns/1ps
module rtcpc_monitor (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // oscillator pin and bus
  input  wire logic        timekeeper_source_clock_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        wb_err_o,
  // events
  input  wire logic        event_ovf_o,
  input  wire logic        event_cmp_o
);
  logic       req;
  logic       osc_q_r;
  logic [3:0] osc_age_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a request is taken only while no answer stands
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

  // cycles since the pin last rose; saturates so a dead oscillator reads old
  always_ff @(posedge clk_i)
  begin
    osc_q_r <= timekeeper_source_clock_i;
    if (rst_i || (timekeeper_source_clock_i && !osc_q_r))
      osc_age_r <= 4'h0;
    else if (osc_age_r != 4'hF)
      osc_age_r <= osc_age_r + 4'h1;
  end

  a_req_answered: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("request not answered in one cycle");
  a_ack_single: assert property ((wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o)
    else $error("answer longer than one cycle");
  a_no_spurious: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_unmapped_err: assert property (req && (wb_adr_i[1:0] != 2'h0 || wb_adr_i > 5'h18) |=> wb_err_o && !wb_ack_o)
    else $error("unmapped address not refused");
  a_ans_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_ovf_pulse: assert property ($rose(event_ovf_o) |=> !event_ovf_o [*3])
    else $error("overflow event not a lone pulse");
  a_evt_near_osc: assert property ((event_ovf_o || event_cmp_o) |-> osc_age_r <= 4'hA)
    else $error("event without an oscillator edge");
endmodule

bind rtcpc_core rtcpc_monitor u_mon (.clk_i, .rst_i, .timekeeper_source_clock_i, .wb_cyc_i, .wb_stb_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .event_ovf_o, .event_cmp_o);

// ### tb/tb_top.sv
// self-checking bench for the prescaled counter core
`timescale 1ns/1ps
module tb_top;
  import rtcpc_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        timekeeper_source_clock_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wb_err_o;
  logic        event_ovf_o;
  logic        event_cmp_o;
  logic        irq_o;
  logic [31:0] rd;
  logic [31:0] c0;
  logic        er;
  int          miscompares;
  int          check_count;
  int          cycles;
  int          ovf_cnt;
  int          cmp_cnt;

  rtcpc_core dut (.clk_i, .rst_i, .timekeeper_source_clock_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .event_ovf_o, .event_cmp_o, .irq_o);

  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // event pulses counted at each edge; both outputs stand one cycle
  always @(posedge clk_i)
  begin
    if (event_ovf_o)
      ovf_cnt++;
    if (event_cmp_o)
      cmp_cnt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // one classic cycle; holds everything until ack or err is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do @(posedge clk_i); while (!(wb_ack_o || wb_err_o));
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  // n oscillator periods, each phase four system clocks
  task automatic osc(input int n);
    repeat (n)
    begin
      timekeeper_source_clock_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      timekeeper_source_clock_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask

  task automatic t_reset();
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b0, ADDR_SYNC, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b0, 5'h1C, 32'h0);
    chk({31'h0, er}, 32'h0000_0001);
    wb(1'b0, 5'h03, 32'h0);
    chk({31'h0, er}, 32'h0000_0001);
    $display("test reset done");
  endtask

  task automatic t_enable();
    wb(1'b1, ADDR_CTRL, 32'h0000_0202);
    wb(1'b0, ADDR_SYNC, 32'h0);
    chk(rd & 32'h1, 32'h0000_0001);
    osc(1);
    wb(1'b0, ADDR_SYNC, 32'h0);
    chk(rd & 32'h1, 32'h0000_0000);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd & 32'h0000_0FCE, 32'h0000_0202);
    osc(2);
    wb(1'b0, ADDR_COUNT, 32'h0);
    c0 = rd;
    osc(8);
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk(rd - c0, 32'h0000_0002);
    $display("test enable done");
  endtask

  task automatic t_protect();
    wb(1'b1, ADDR_EVCTL, 32'h0000_0003);
    wb(1'b0, ADDR_EVCTL, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b1, ADDR_CTRL, 32'h0000_0302);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd & 32'h0000_0FCE, 32'h0000_0202);
    wb(1'b1, ADDR_CTRL, 32'h0000_0500);
    osc(2);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd & 32'h0000_0FCE, 32'h0000_0200);
    wb(1'b0, ADDR_COUNT, 32'h0);
    c0 = rd;
    chk(c0, 32'h0000_0002);
    osc(8);
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk(rd, c0);
    $display("test protect done");
  endtask

  // every control write raises busy, so each protected change waits one oscillator edge
  task automatic t_modes();
    wb(1'b1, ADDR_CTRL, 32'h0000_00C8);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd & 32'h0000_0FCE, 32'h0000_00C8);
    osc(1);
    wb(1'b0, ADDR_SYNC, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b1, ADDR_CTRL, 32'h0000_000C);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd & 32'h0000_0FCE, 32'h0000_0000);
    osc(1);
    wb(1'b0, ADDR_SYNC, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b1, ADDR_COUNT, 32'h0000_FFFE);
    wb(1'b1, ADDR_EVCTL, 32'h0000_0001);
    wb(1'b0, ADDR_EVCTL, 32'h0);
    chk(rd, 32'h0000_0001);
    wb(1'b1, ADDR_CTRL, 32'h0000_0006);
    osc(6);
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk(rd >> 16, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    chk(ovf_cnt, 32'h0000_0001);
    chk(cmp_cnt, 32'h0000_0000);
    wb(1'b0, ADDR_IRQST, 32'h0);
    chk(rd & 32'h1, 32'h0000_0001);
    chk({31'h0, irq_o}, 32'h0000_0000);
    wb(1'b1, ADDR_IRQMK, 32'h0000_0001);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wb(1'b1, ADDR_IRQST, 32'h0000_0001);
    chk({31'h0, irq_o}, 32'h0000_0000);
    $display("test modes done");
  endtask

  // stop, wait for sync, then run the calendar from 59 seconds
  task automatic t_calendar();
    wb(1'b1, ADDR_CTRL, 32'h0);
    osc(1);
    wb(1'b0, ADDR_SYNC, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b1, ADDR_COUNT, 32'h0000_003B);
    // the source is taken as 1 Hz here, so prescaler 0 is the 1 Hz tick
    wb(1'b1, ADDR_CTRL, 32'h0000_000A);
    osc(2);
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk(rd, 32'h0000_0040);
    $display("test calendar done");
  endtask

  // inputs valued at time zero, reset for two cycles, then the scenarios
  initial
  begin
    rst_i = 1'b1;
    timekeeper_source_clock_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_enable();
    t_protect();
    t_modes();
    t_calendar();
    print_verdict();
  end
endmodule
